// ==== logic/ist_timing.sv ====
// What this block does
// - total states is sum of count times cost
// - on-chip and internal cycles cost two states
// - register field: byte three, word/branch six
// - external: byte 3+m, others 6+2m
// - peripheral-sync external byte access takes 9 to 16
// - push and pop decode as plain move
// - branch aliases share code with base branches
// - first byte selects, bit 7 separates the synced move pair
`timescale 1ns/1ps
`default_nettype none
`include "ist_defines.svh"

module ist_timing #(
    parameter int WAIT_W = 4
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // instruction request, same-domain from the core
    input wire logic req_i,
    input wire logic [15:0] instr_i,
    input wire ist_pkg::ist_counts_t counts_i,
    input wire ist_pkg::ist_locs_t locs_i,
    input wire logic [WAIT_W-1:0] wait_i,
    // measured external byte states for synced moves, 9..16
    input wire logic [4:0] sync_states_i,
    // results
    output logic valid_o,
    output ist_pkg::ist_cls_t cls_o,
    output logic [9:0] states_o
);

    // per-type costs from the shared cost unit; 6 bits since 6+2m reaches 36
    logic [5:0] cost_fetch;
    logic [5:0] cost_br;
    logic [5:0] cost_stack;
    logic [5:0] cost_byte;
    logic [5:0] cost_word;
    logic [5:0] cost_byte_eff; // byte cost after the synced-move override
    logic [4:0] sync_clamped; // synced byte states forced into 9..16
    logic sync_move; // current opcode is one of the synced moves
    logic [3:0] wait_cap; // wait count as the cost unit sees it
    logic [7:0] opcode; // first instruction byte
    logic subsel; // first bit of the second byte
    ist_pkg::ist_cls_t cls_dec; // class of the presented instruction
    // weighted terms, one per cycle type; kept apart so a wrong total
    // can be traced to the cycle type that caused it
    logic [9:0] term_fetch;
    logic [9:0] term_br;
    logic [9:0] term_stack;
    logic [9:0] term_byte;
    logic [9:0] term_word;
    logic [9:0] term_internal;
    logic [11:0] total_wide; // unsaturated sum of the six terms
    logic [9:0] total; // sum as it is reported

    // registered outputs
    logic valid_reg;
    logic valid_next;
    ist_pkg::ist_cls_t cls_reg;
    ist_pkg::ist_cls_t cls_next;
    logic [9:0] states_reg;
    logic [9:0] states_next;

    // the cost unit takes a 4-bit wait count; wider counts saturate rather
    // than wrap, so a slow external device never looks faster than 15 waits
    generate
        if (WAIT_W > 4) begin : g_wait_sat
            // any wait above 15 is reported as 15; totals are then a lower bound
            always_comb begin
                wait_cap = wait_i[3:0];
                if (|wait_i[WAIT_W-1:4]) begin
                    wait_cap = 4'hf;
                end
            end
        end else if (WAIT_W == 4) begin : g_wait_full
            // native width, passed straight through
            assign wait_cap = wait_i;
        end else begin : g_wait_ext
            // narrow counts are zero-extended on purpose
            assign wait_cap = {{(4 - WAIT_W){1'b0}}, wait_i};
        end
    endgenerate

    // branch address reads are word-sized
    ist_cycle_cost u_cost_fetch (
        .loc_i(locs_i.fetch),
        .is_byte_i(1'b0),
        .wait_i(wait_cap),
        .cost_o(cost_fetch)
    );
    ist_cycle_cost u_cost_br (
        .loc_i(locs_i.br_addr),
        .is_byte_i(1'b0),
        .wait_i(wait_cap),
        .cost_o(cost_br)
    );
    ist_cycle_cost u_cost_stack (
        .loc_i(locs_i.stack),
        .is_byte_i(1'b0),
        .wait_i(wait_cap),
        .cost_o(cost_stack)
    );
    ist_cycle_cost u_cost_byte (
        .loc_i(locs_i.byte_acc),
        .is_byte_i(1'b1),
        .wait_i(wait_cap),
        .cost_o(cost_byte)
    );
    ist_cycle_cost u_cost_word (
        .loc_i(locs_i.word_acc),
        .is_byte_i(1'b0),
        .wait_i(wait_cap),
        .cost_o(cost_word)
    );

    // opcode split: first byte plus the sub-select bit
    assign opcode = instr_i[`IST_OP_HI:`IST_OP_LO];
    assign subsel = instr_i[`IST_SUBSEL_BIT];

    // decode; aliases have no codes of their own so they land here too
    always_comb begin
        unique case (opcode)
            `IST_OP_BR_ALWAYS: begin
                // also the branch_true_alias spelling
                cls_dec = ist_pkg::IST_CLS_BRANCH_ALWAYS;
            end
            `IST_OP_BR_NEVER: begin
                // also the branch_false_alias spelling
                cls_dec = ist_pkg::IST_CLS_BRANCH_NEVER;
            end
            `IST_OP_BR_CC: begin
                // also the branch_higher_same_alias spelling
                cls_dec = ist_pkg::IST_CLS_BRANCH_CARRY_CLEAR;
            end
            `IST_OP_BR_CS: begin
                // also the branch_lower_alias spelling
                cls_dec = ist_pkg::IST_CLS_BRANCH_CARRY_SET;
            end
            `IST_OP_MOV_POSTINC: begin
                // push/pop share bits 15..8 with move; no separate class
                cls_dec = ist_pkg::IST_CLS_PLAIN_MOVE;
            end
            `IST_OP_MOV_PSYNC: begin
                // bit 7 separates the two synced moves
                cls_dec = subsel ? ist_pkg::IST_CLS_MOVE_TO_PSYNC
                                 : ist_pkg::IST_CLS_MOVE_FROM_PSYNC;
            end
            default: begin
                // everything outside this block's opcode set
                cls_dec = ist_pkg::IST_CLS_OTHER;
            end
        endcase
    end

    // synced moves replace the external byte cost with the clock-locked one
    always_comb begin
        // a reading outside 9..16 is a measurement glitch; clamping keeps
        // the total inside the bound the core relies on
        sync_clamped = sync_states_i;
        if (sync_states_i < `IST_SYNC_MIN) begin
            sync_clamped = `IST_SYNC_MIN;
        end else if (sync_states_i > `IST_SYNC_MAX) begin
            sync_clamped = `IST_SYNC_MAX;
        end
        // either move of the synced pair, whatever its direction
        sync_move = (cls_dec == ist_pkg::IST_CLS_MOVE_FROM_PSYNC) ||
                    (cls_dec == ist_pkg::IST_CLS_MOVE_TO_PSYNC);
        cost_byte_eff = cost_byte;
        // only an external byte access is locked to the sync clock; on-chip
        // and register-field bytes of these moves keep their normal cost
        if (sync_move && locs_i.byte_acc == ist_pkg::IST_LOC_EXT) begin
            cost_byte_eff = {1'b0, sync_clamped};
        end
    end

    // weighted sum over the six cycle types; one term reaches 15 x 36 at most
    always_comb begin
        term_fetch = 10'(counts_i.fetch * cost_fetch);
        term_br = 10'(counts_i.br_addr * cost_br);
        term_stack = 10'(counts_i.stack * cost_stack);
        term_byte = 10'(counts_i.byte_acc * cost_byte_eff);
        term_word = 10'(counts_i.word_acc * cost_word);
        term_internal = 10'(counts_i.internal * `IST_COST_INTERNAL);
        // the sum needs 12 bits in the worst case
        total_wide = 12'(term_fetch) + 12'(term_br) + 12'(term_stack)
                   + 12'(term_byte) + 12'(term_word) + 12'(term_internal);
        // limitation: totals beyond 1023 states saturate instead of wrapping;
        // no real instruction comes near, but a wrapped value would look short
        total = 10'h3ff;
        if (total_wide[11:10] == 2'b00) begin
            total = total_wide[9:0];
        end
    end

    // next-state for outputs; class and states hold until the next request, valid follows req_i
    always_comb begin
        valid_next = req_i;
        cls_next = cls_reg;
        states_next = states_reg;
        if (req_i) begin
            cls_next = cls_dec;
            states_next = total;
        end
    end

    // output registers; every output leaves a flip-flop so the core sees
    // a clean launch point instead of the long multiply-add path
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            valid_reg <= 1'b0;
            cls_reg <= ist_pkg::IST_CLS_OTHER;
            states_reg <= 10'h000;
        end else begin
            valid_reg <= valid_next;
            cls_reg <= cls_next;
            states_reg <= states_next;
        end
    end

    assign valid_o = valid_reg;
    assign cls_o = cls_reg;
    assign states_o = states_reg;

endmodule : ist_timing
`default_nettype wire

// ==== logic/ist_defines.svh ====
`ifndef IST_DEFINES_SVH
`define IST_DEFINES_SVH

// state costs per cycle, by access location; six bits since 6+2m reaches 36
`define IST_COST_ONCHIP 6'h02
`define IST_COST_REG_BYTE 6'h03
`define IST_COST_REG_WORD 6'h06
`define IST_COST_EXT_BYTE_BASE 6'h03
`define IST_COST_EXT_WORD_BASE 6'h06
`define IST_COST_INTERNAL 6'h02
// synchronized peripheral byte access bounds
`define IST_SYNC_MIN 5'h09
`define IST_SYNC_MAX 5'h10
// opcode bytes of the branch family that carry aliases
`define IST_OP_BR_ALWAYS 8'h40
`define IST_OP_BR_NEVER 8'h41
`define IST_OP_BR_CC 8'h44
`define IST_OP_BR_CS 8'h45
// opcode bytes shared by stack push/pop and move
`define IST_OP_MOV_POSTINC 8'h6d
// opcode byte of the peripheral-sync move pair
`define IST_OP_MOV_PSYNC 8'h6a
// opcode field positions in the first instruction word
`define IST_OP_HI 15
`define IST_OP_LO 8
`define IST_SUBSEL_BIT 7

`endif

// ==== logic/ist_pkg.sv ====
package ist_pkg;

    // access location of a bus cycle
    typedef enum logic [1:0] {
        IST_LOC_ONCHIP = 2'h0,
        IST_LOC_REGFLD = 2'h1,
        IST_LOC_EXT = 2'h2
    } ist_loc_t;

    // decoded instruction class
    typedef enum logic [3:0] {
        IST_CLS_OTHER = 4'h0,
        IST_CLS_BRANCH_ALWAYS = 4'h1,
        IST_CLS_BRANCH_NEVER = 4'h2,
        IST_CLS_BRANCH_CARRY_CLEAR = 4'h3,
        IST_CLS_BRANCH_CARRY_SET = 4'h4,
        IST_CLS_PLAIN_MOVE = 4'h5,
        IST_CLS_MOVE_FROM_PSYNC = 4'h6,
        IST_CLS_MOVE_TO_PSYNC = 4'h7
    } ist_cls_t;

    // per-instruction cycle counts, one field per cycle type
    typedef struct packed {
        logic [3:0] fetch;
        logic [3:0] br_addr;
        logic [3:0] stack;
        logic [3:0] byte_acc;
        logic [3:0] word_acc;
        logic [3:0] internal;
    } ist_counts_t;

    // access locations of the data-carrying cycle types
    typedef struct packed {
        ist_loc_t fetch;
        ist_loc_t br_addr;
        ist_loc_t stack;
        ist_loc_t byte_acc;
        ist_loc_t word_acc;
    } ist_locs_t;

endpackage : ist_pkg

// ==== logic/ist_cycle_cost.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ist_defines.svh"

// state cost of one cycle of a given kind at a given location
module ist_cycle_cost (
    // cycle description
    input wire ist_pkg::ist_loc_t loc_i,
    input wire logic is_byte_i,
    input wire logic [3:0] wait_i,
    // result; a 4-bit wait count gives at most 36 states, hence six bits
    output logic [5:0] cost_o
);

    // word-sized cycles in the register field cost 6, bytes 3
    always_comb begin
        unique case (loc_i)
            ist_pkg::IST_LOC_ONCHIP: begin
                cost_o = `IST_COST_ONCHIP;
            end
            ist_pkg::IST_LOC_REGFLD: begin
                cost_o = is_byte_i ? `IST_COST_REG_BYTE : `IST_COST_REG_WORD;
            end
            ist_pkg::IST_LOC_EXT: begin
                // 3+m for bytes, 6+2m for word-sized cycles
                cost_o = is_byte_i ? (`IST_COST_EXT_BYTE_BASE + {2'b00, wait_i})
                                   : (`IST_COST_EXT_WORD_BASE + {1'b0, wait_i, 1'b0});
            end
            default: begin
                // unused location code treated as on-chip
                cost_o = `IST_COST_ONCHIP;
            end
        endcase
    end

endmodule : ist_cycle_cost
`default_nettype wire

// ==== tb/ist_timing_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module ist_timing_chk #(
    parameter int WAIT_W = 4
) (
    // clock, reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // request side
    input wire logic req_i,
    input wire logic [15:0] instr_i,
    input wire ist_pkg::ist_counts_t counts_i,
    input wire ist_pkg::ist_locs_t locs_i,
    input wire logic [WAIT_W-1:0] wait_i,
    input wire logic [4:0] sync_states_i,
    // results
    input wire logic valid_o,
    input wire ist_pkg::ist_cls_t cls_o,
    input wire logic [9:0] states_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    a_valid_after_req: assert property (req_i |=> valid_o)
        else $error("valid missing after request");
    a_idle_holds: assert property (!req_i |=> !valid_o && $stable(states_o))
        else $error("outputs moved without request");
    a_internal_only: assert property (req_i && counts_i[23:4] == 20'h0
        |=> states_o == {5'h0, $past(counts_i[3:0]), 1'b0}) else $error("internal cost");
    a_fetch_onchip: assert property (req_i && counts_i == 24'h100000
        && locs_i.fetch == ist_pkg::IST_LOC_ONCHIP |=> states_o == 10'h2) else $error("onchip");
    a_reg_byte: assert property (req_i && counts_i == 24'h000100
        && locs_i.byte_acc == ist_pkg::IST_LOC_REGFLD |=> states_o == 10'h3) else $error("reg byte");
    a_reg_word: assert property (req_i && counts_i == 24'h000010
        && locs_i.word_acc == ist_pkg::IST_LOC_REGFLD |=> states_o == 10'h6) else $error("reg word");
    a_ext_word: assert property (req_i && counts_i == 24'h000010
        && locs_i.word_acc == ist_pkg::IST_LOC_EXT
        |=> states_o == 10'h6 + 2 * $past(wait_i)) else $error("ext word");
    a_sync_range: assert property (req_i && instr_i[15:8] == 8'h6a && counts_i == 24'h000100
        && locs_i.byte_acc == ist_pkg::IST_LOC_EXT |=> states_o inside {[10'h9:10'h10]})
        else $error("sync byte out of range");
    a_push_is_move: assert property (req_i && instr_i[15:8] == 8'h6d
        |=> cls_o == ist_pkg::IST_CLS_PLAIN_MOVE) else $error("push/pop class");
    a_alias_always: assert property (req_i && instr_i[15:9] == 7'h20
        |=> cls_o == 4'h1 + $past(instr_i[8])) else $error("always/never class");
    a_alias_carry: assert property (req_i && instr_i[15:9] == 7'h22
        |=> cls_o == 4'h3 + $past(instr_i[8])) else $error("carry class");
    a_sync_subsel: assert property (req_i && instr_i[15:8] == 8'h6a
        |=> cls_o == 4'h6 + $past(instr_i[7])) else $error("sync pair split");
    c_sync: cover property (req_i && instr_i[15:8] == 8'h6a);
    c_branch: cover property (req_i && instr_i[15:9] == 7'h22);
    c_move: cover property (req_i && instr_i[15:8] == 8'h6d);
endmodule : ist_timing_chk
bind ist_timing ist_timing_chk #(.WAIT_W(WAIT_W)) i_ist_timing_chk (.mclk_i, .arst_n_i,
    .req_i, .instr_i, .counts_i, .locs_i, .wait_i, .sync_states_i, .valid_o, .cls_o, .states_o);
`default_nettype wire

// ==== tb/ist_psync_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// peripheral sync clock phase: byte access lands 9..16 states away
module ist_psync_model (
    // clock
    input wire logic mclk_i,
    // measured sync cost
    output logic [4:0] sync_states_o
);
    // free running phase, moves on falling edge to stay off the sample edge
    initial sync_states_o = 5'h09;
    always @(negedge mclk_i) begin
        sync_states_o <= (sync_states_o == 5'h10) ? 5'h09 : sync_states_o + 5'h01;
    end
endmodule : ist_psync_model
`default_nettype wire

// ==== tb/ist_timing_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module ist_timing_test;
    logic mclk_i = 0, arst_n_i = 0, req_i = 0, valid_o;
    logic [15:0] instr_i = 16'h0;
    ist_pkg::ist_counts_t counts_i = '0, c;
    ist_pkg::ist_locs_t locs_i = '0, l;
    logic [3:0] wait_i = 4'h0;
    logic [4:0] sync_states_i;
    ist_pkg::ist_cls_t cls_o;
    logic [9:0] states_o, e;
    logic [7:0] ops [7] = '{8'h40, 8'h41, 8'h44, 8'h45, 8'h6d, 8'h6a, 8'h00};
    int err_total = 0, n_tests = 0;
    ist_timing #(.WAIT_W(4)) i_ist_timing (.mclk_i, .arst_n_i, .req_i, .instr_i, .counts_i,
        .locs_i, .wait_i, .sync_states_i, .valid_o, .cls_o, .states_o);
    ist_psync_model i_ist_psync_model (.mclk_i, .sync_states_o(sync_states_i));
    initial forever #2 mclk_i = ~mclk_i;
    task summarize;
        if (err_total == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    task chk(input logic [9:0] got, input logic [9:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // cost of one cycle by location; ext word-class grows twice per wait
    function automatic logic [9:0] cst(logic [1:0] lc, logic b, logic [3:0] m);
        return lc == 2'h0 ? 10'h2 : lc == 2'h1 ? (b ? 10'h3 : 10'h6) : (b ? 10'h3 + m : 10'h6 + 2 * m);
    endfunction : cst
    function automatic logic [3:0] ecls(logic [15:0] i);
        case (i[15:8])
            8'h40: return 4'h1;
            8'h41: return 4'h2;
            8'h44: return 4'h3;
            8'h45: return 4'h4;
            8'h6d: return 4'h5;
            8'h6a: return i[7] ? 4'h7 : 4'h6;
            default: return 4'h0;
        endcase
    endfunction : ecls
    // one request, checked one edge later; back to back by design
    task run(input logic [15:0] ins, input logic [3:0] m);
        logic [9:0] bc;
        req_i = 1;
        instr_i = ins;
        counts_i = c;
        locs_i = l;
        wait_i = m;
        @(posedge mclk_i);
        bc = (ins[15:8] == 8'h6a && l.byte_acc == 2'h2) ? {5'h0, sync_states_i} : cst(l.byte_acc, 1, m);
        e = c.fetch * cst(l.fetch, 0, m) + c.br_addr * cst(l.br_addr, 0, m)
            + c.stack * cst(l.stack, 0, m) + c.word_acc * cst(l.word_acc, 0, m)
            + c.internal * 10'h2 + c.byte_acc * bc;
        @(negedge mclk_i);
        chk({9'h0, valid_o}, 10'h1);
        chk(states_o, e);
        chk({6'h0, cls_o}, {6'h0, ecls(ins)});
    endtask : run
    initial begin
        #5000 err_total++;
        summarize();
    end
    initial begin
        void'($urandom(32'h783b35b0));
        repeat (3) @(negedge mclk_i);
        arst_n_i = 1;
        // each cycle type alone at each location, sync pair opcode
        for (int lc = 0; lc < 3; lc++) begin
            for (int t = 0; t < 6; t++) begin
                c = '0;
                c[23 - 4 * t -: 4] = 4'h1;
                l = {5{2'(lc)}};
                run({8'h6a, t[0], 7'h0}, 4'($urandom));
            end
        end
        // random mixes over the alias and move opcodes plus the default opcode 8'h00
        repeat (200) begin
            for (int j = 0; j < 6; j++) c[4 * j +: 4] = 4'($urandom % 4);
            for (int j = 0; j < 5; j++) l[2 * j +: 2] = 2'($urandom % 3);
            run({ops[$urandom % 7], 8'($urandom)}, 4'($urandom));
        end
        req_i = 0;
        @(negedge mclk_i);
        chk({9'h0, valid_o}, 10'h0);
        chk(states_o, e);
        // reset in mid-run clears every output, then a word cycle at the top wait count
        arst_n_i = 0;
        @(negedge mclk_i);
        chk({9'h0, valid_o}, 10'h0);
        chk(states_o, 10'h0);
        chk({6'h0, cls_o}, 10'h0);
        arst_n_i = 1;
        c = 24'h000010;
        l = {5{2'h2}};
        run(16'h4400, 4'hf);
        summarize();
    end
endmodule : ist_timing_test
`default_nettype wire
